// ---- rtl/flash_host_pkg.sv ----
// Package with constants and operation modes for the parallel flash host.
package flash_host_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	// Unlock addresses and command codes are not given; plain defaults.
	localparam logic [19:0] UNLOCK_A1 = 20'h0_0555;
	localparam logic [19:0] UNLOCK_A2 = 20'h0_02AA;
	localparam logic [15:0] UNLOCK_D1 = 16'h00AA;
	localparam logic [15:0] UNLOCK_D2 = 16'h0055;
	localparam logic [15:0] CMD_PROG = 16'h00A0;
	localparam logic [15:0] CMD_ERASE = 16'h0080;
	localparam logic [15:0] CMD_SECT = 16'h0030;
	localparam logic [15:0] CMD_BYPASS = 16'h0020;
	localparam logic [15:0] CMD_SUSP = 16'h00B0;
	localparam logic [15:0] CMD_RESUME = 16'h0030;
	localparam logic [15:0] CMD_RESET = 16'h00F0;
	localparam logic [15:0] CMD_REGION = 16'h0088;
	localparam logic [15:0] CMD_EXIT = 16'h0090;
	// Bus timing at 50 ns per cycle: access 90 ns, strobe 50 ns.
	localparam int CLK_NS = 50;
	localparam int ACCESS_NS = 90;
	localparam int STROBE_NS = 50;
	localparam int HRESET_NS = 500;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HRESET_CYC = (HRESET_NS + CLK_NS - 1) / CLK_NS;
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	typedef enum logic [3:0] {
		OP_READ = 4'h0, OP_PROG = 4'h1, OP_ERASE = 4'h2,
		OP_BYPASS_ON = 4'h3, OP_BYPASS_PROG = 4'h4, OP_SUSPEND = 4'h5,
		OP_RESUME = 4'h6, OP_HWRESET = 4'h7, OP_REGION_ON = 4'h8,
		OP_REGION_OFF = 4'h9, OP_BYPASS_OFF = 4'hA
	} op_e;
endpackage

// ---- rtl/flash_cycle_if.sv ----
// Interface between the sequencer and its bus cycle engine.
`timescale 1ns/1ps
interface flash_cycle_if;
	logic        req;
	logic        wr;
	logic [19:0] addr;
	logic [15:0] wdata;
	logic        done;
	logic [15:0] rdata;
	modport seq (output req, wr, addr, wdata, input done, rdata);
	modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface

// ---- rtl/flash_bus_cycle.sv ----
// Single read or write cycle engine on the flash strobes.
`timescale 1ns/1ps
module flash_bus_cycle
	import flash_host_pkg::*;
(
	input  wire logic          clk_i,
	input  wire logic          rstn_i,
	flash_cycle_if.eng         cyc,
	input  wire logic [15:0]   dq_in_i,
	output logic               ce_n_o,
	output logic               we_n_o,
	output logic               oe_n_o,
	output logic [19:0]        addr_o,
	output logic [15:0]        dq_out_o,
	output logic               dq_oe_o
);
	logic [3:0] cnt_r;
	logic       busy_r;
	logic       wr_r;

	// Strobes stay apart so host and flash never both drive data.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_r <= 4'h0;
			busy_r <= 1'b0;
			wr_r <= 1'b0;
			ce_n_o <= 1'b1;
			we_n_o <= 1'b1;
			oe_n_o <= 1'b1;
			addr_o <= 20'h0_0000;
			dq_out_o <= 16'h0000;
			dq_oe_o <= 1'b0;
			cyc.done <= 1'b0;
			cyc.rdata <= 16'h0000;
		end else begin
			cyc.done <= 1'b0;
			if (!busy_r && cyc.req) begin
				busy_r <= 1'b1;
				wr_r <= cyc.wr;
				cnt_r <= cyc.wr ? 4'(STROBE_CYC) : 4'(ACCESS_CYC);
				addr_o <= cyc.addr;
				dq_out_o <= cyc.wdata;
				dq_oe_o <= cyc.wr;
				ce_n_o <= 1'b0;
				we_n_o <= !cyc.wr;
				oe_n_o <= cyc.wr;
			end else if (busy_r) begin
				if (cnt_r != 4'h0) begin
					cnt_r <= cnt_r - 4'h1;
				end else begin
					// Release strobes first; data stays one more cycle.
					busy_r <= 1'b0;
					ce_n_o <= 1'b1;
					we_n_o <= 1'b1;
					oe_n_o <= 1'b1;
					cyc.done <= 1'b1;
					if (!wr_r) begin
						cyc.rdata <= dq_in_i;
					end
				end
			end else begin
				dq_oe_o <= 1'b0;
			end
		end
	end
endmodule

// ---- rtl/flash_host_ctrl.sv ----
// Host controller that sequences commands into a parallel NOR flash.
`timescale 1ns/1ps
// How it works
// - Program and erase use full unlock sequences.
// - Bypass mode programs with two writes.
// - Erase suspend lets host read or program.
// - Suspend does not limit the host to reads.
// - Strobes sequenced so buses never collide.
module flash_host_ctrl
	import flash_host_pkg::*;
(
	input  wire logic                     CLK_SYS_I,
	input  wire logic                     RSTN_I,
	input  wire logic                     START_I,
	input  wire flash_host_pkg::op_e      OP_I,
	input  wire logic [19:0]              ADDR_I,
	input  wire logic [15:0]              DATA_I,
	input  wire logic                     BYTE_MODE_I,
	output logic                          BUSY_O,
	output logic                          DONE_O,
	output logic                          ERROR_O,
	output logic [15:0]                   RDATA_O,
	output logic                          SUSPENDED_O,
	output logic                          FLASH_CE_N_O,
	output logic                          FLASH_WE_N_O,
	output logic                          FLASH_OE_N_O,
	output logic                          FLASH_RESET_N_O,
	output logic                          FLASH_BYTE_N_O,
	output logic [19:0]                   FLASH_ADDR_O,
	output logic [15:0]                   FLASH_DQ_O,
	output logic                          FLASH_DQ_OE_O,
	input  wire logic [15:0]              FLASH_DQ_I,
	input  wire logic                     FLASH_READY_BUSY_N_I
);
	import flash_host_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_CMD = 3'b001, ST_POLL = 3'b010,
		ST_READ = 3'b011, ST_HWRST = 3'b100, ST_FINISH = 3'b101
	} state_e;

	flash_cycle_if cyc ();

	state_e      state_r;
	op_e         op_r;
	logic [2:0]  step_r;
	logic [2:0]  nsteps_r;
	logic [19:0] addr_r;
	logic [15:0] data_r;
	logic [15:0] last_r;
	logic        have_last_r;
	logic        bypass_r;
	logic        pend_r;
	logic [4:0]  rst_cnt_r;
	logic        req_r;
	logic        wr_r;
	logic [19:0] caddr_r;
	logic [15:0] cdata_r;
	logic        ce_n_w;
	logic        we_n_w;
	logic        oe_n_w;
	logic [19:0] fa_w;
	logic [15:0] fd_w;
	logic        fdoe_w;

	assign cyc.req = req_r;
	assign cyc.wr = wr_r;
	assign cyc.addr = caddr_r;
	assign cyc.wdata = cdata_r;

	// Number of writes each operation needs.
	function automatic logic [2:0] steps_of(input op_e op, input logic byp);
		unique case (op)
			OP_PROG: steps_of = 3'd4;
			OP_ERASE: steps_of = 3'd6;
			OP_BYPASS_ON: steps_of = 3'd3;
			OP_BYPASS_PROG: steps_of = byp ? 3'd2 : 3'd4;
			OP_BYPASS_OFF: steps_of = 3'd2;
			OP_REGION_ON: steps_of = 3'd3;
			OP_REGION_OFF: steps_of = 3'd4;
			OP_SUSPEND: steps_of = 3'd1;
			OP_RESUME: steps_of = 3'd1;
			default: steps_of = 3'd0;
		endcase
	endfunction

	// Address and data of write number step for the given operation.
	function automatic logic [35:0] word_of(input op_e op, input logic byp,
			input logic [2:0] st, input logic [19:0] a, input logic [15:0] d);
		logic [19:0] wa;
		logic [15:0] wd;
		wa = (st[0]) ? UNLOCK_A2 : UNLOCK_A1;
		wd = (st[0]) ? UNLOCK_D2 : UNLOCK_D1;
		if (op == OP_SUSPEND) begin
			wa = a;
			wd = CMD_SUSP;
		end else if (op == OP_RESUME) begin
			wa = a;
			wd = CMD_RESUME;
		end else if (op == OP_BYPASS_PROG && byp) begin
			wa = st[0] ? a : 20'h0_0000;
			wd = st[0] ? d : CMD_PROG;
		end else if (op == OP_BYPASS_OFF) begin
			wa = 20'h0_0000;
			wd = st[0] ? 16'h0000 : CMD_EXIT;
		end else if (op == OP_ERASE && st >= 3'd2) begin
			// Six-cycle sector erase, sector address last.
			unique case (st)
				3'd2: wd = CMD_ERASE;
				// Second unlock pair restarts with the first word.
				3'd3: begin
					wa = UNLOCK_A1;
					wd = UNLOCK_D1;
				end
				3'd4: begin
					wa = UNLOCK_A2;
					wd = UNLOCK_D2;
				end
				3'd5: begin
					wa = a;
					wd = CMD_SECT;
				end
				default: wa = wa;
			endcase
		end else if (st == 3'd2) begin
			unique case (op)
				OP_BYPASS_ON: wd = CMD_BYPASS;
				OP_REGION_ON: wd = CMD_REGION;
				OP_REGION_OFF: wd = CMD_EXIT;
				default: wd = CMD_PROG;
			endcase
		end else if (st == 3'd3) begin
			wa = (op == OP_REGION_OFF) ? 20'h0_0000 : a;
			wd = (op == OP_REGION_OFF) ? 16'h0000 : d;
		end
		word_of = {wa, wd};
	endfunction

	// Main sequencer: a new request is only taken in idle.
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_r <= ST_IDLE;
			op_r <= OP_READ;
			step_r <= 3'd0;
			nsteps_r <= 3'd0;
			addr_r <= 20'h0_0000;
			data_r <= 16'h0000;
			last_r <= 16'h0000;
			have_last_r <= 1'b0;
			bypass_r <= 1'b0;
			pend_r <= 1'b0;
			SUSPENDED_O <= 1'b0;
			rst_cnt_r <= 5'd0;
			req_r <= 1'b0;
			wr_r <= 1'b0;
			caddr_r <= 20'h0_0000;
			cdata_r <= 16'h0000;
			BUSY_O <= 1'b0;
			DONE_O <= 1'b0;
			ERROR_O <= 1'b0;
			RDATA_O <= 16'h0000;
			FLASH_RESET_N_O <= 1'b0;
		end else begin
			DONE_O <= 1'b0;
			req_r <= 1'b0;
			unique case (state_r)
				ST_IDLE: begin
					FLASH_RESET_N_O <= 1'b1;
					if (START_I) begin
						op_r <= OP_I;
						addr_r <= ADDR_I;
						data_r <= DATA_I;
						step_r <= 3'd0;
						nsteps_r <= steps_of(OP_I, bypass_r);
						BUSY_O <= 1'b1;
						ERROR_O <= 1'b0;
						have_last_r <= 1'b0;
						pend_r <= 1'b0;
						if (OP_I == OP_HWRESET) begin
							FLASH_RESET_N_O <= 1'b0;
							rst_cnt_r <= 5'(HRESET_CYC);
							state_r <= ST_HWRST;
						end else if (OP_I == OP_READ) begin
							req_r <= 1'b1;
							wr_r <= 1'b0;
							caddr_r <= ADDR_I;
							state_r <= ST_READ;
						end else begin
							state_r <= ST_CMD;
						end
					end
				end
				ST_CMD: begin
					// Every step is a fresh write that the flash latches.
					// Only one cycle in flight, or a stray access follows.
					if (!req_r && !pend_r && !cyc.done && step_r < nsteps_r &&
							!(step_r != 3'd0 && !have_last_r)) begin
						req_r <= 1'b1;
						wr_r <= 1'b1;
						{caddr_r, cdata_r} <= word_of(op_r, bypass_r,
							step_r, addr_r, data_r);
						have_last_r <= 1'b0;
						pend_r <= 1'b1;
					end
					if (cyc.done) begin
						have_last_r <= 1'b1;
						pend_r <= 1'b0;
						step_r <= step_r + 3'd1;
						if (step_r + 3'd1 == nsteps_r) begin
							if (op_r == OP_PROG || op_r == OP_ERASE ||
									op_r == OP_BYPASS_PROG || op_r == OP_RESUME) begin
								have_last_r <= 1'b0;
								state_r <= ST_POLL;
								if (op_r == OP_RESUME) begin
									SUSPENDED_O <= 1'b0;
								end
							end else begin
								state_r <= ST_FINISH;
							end
							if (op_r == OP_BYPASS_ON) bypass_r <= 1'b1;
							if (op_r == OP_BYPASS_OFF) bypass_r <= 1'b0;
							if (op_r == OP_SUSPEND) begin
								SUSPENDED_O <= 1'b1;
							end
						end
					end
				end
				ST_POLL: begin
					// Status reads until the toggle bit holds still.
					if (!req_r && !pend_r && !cyc.done) begin
						req_r <= 1'b1;
						pend_r <= 1'b1;
						wr_r <= 1'b0;
						caddr_r <= addr_r;
					end
					if (cyc.done) begin
						pend_r <= 1'b0;
						last_r <= cyc.rdata;
						have_last_r <= 1'b1;
						if (have_last_r && FLASH_READY_BUSY_N_I &&
								cyc.rdata[TOGGLE_BIT] == last_r[TOGGLE_BIT]) begin
							// Still different data means refused write.
							ERROR_O <= (op_r != OP_ERASE && op_r != OP_RESUME &&
								cyc.rdata != data_r);
							state_r <= ST_FINISH;
						end
					end
				end
				ST_READ: begin
					if (cyc.done) begin
						// Byte mode only keeps the low lane.
						RDATA_O <= BYTE_MODE_I ? {8'h00, cyc.rdata[7:0]}
							: cyc.rdata;
						state_r <= ST_FINISH;
					end
				end
				ST_HWRST: begin
					if (rst_cnt_r != 5'd0) begin
						rst_cnt_r <= rst_cnt_r - 5'd1;
					end else begin
						FLASH_RESET_N_O <= 1'b1;
						bypass_r <= 1'b0;
						SUSPENDED_O <= 1'b0;
						state_r <= ST_FINISH;
					end
				end
				ST_FINISH: begin
					BUSY_O <= 1'b0;
					DONE_O <= 1'b1;
					state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Chip enable idles high so the flash drops to standby.
	flash_bus_cycle u_cycle (
		.clk_i    (CLK_SYS_I),
		.rstn_i   (RSTN_I),
		.cyc      (cyc),
		.dq_in_i  (FLASH_DQ_I),
		.ce_n_o   (ce_n_w),
		.we_n_o   (we_n_w),
		.oe_n_o   (oe_n_w),
		.addr_o   (fa_w),
		.dq_out_o (fd_w),
		.dq_oe_o  (fdoe_w)
	);

	// The engine outputs are already flops; this stage keeps ports flopped.
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			FLASH_CE_N_O <= 1'b1;
			FLASH_WE_N_O <= 1'b1;
			FLASH_OE_N_O <= 1'b1;
			FLASH_ADDR_O <= 20'h0_0000;
			FLASH_DQ_O <= 16'h0000;
			FLASH_DQ_OE_O <= 1'b0;
			FLASH_BYTE_N_O <= 1'b1;
		end else begin
			FLASH_CE_N_O <= ce_n_w;
			FLASH_WE_N_O <= we_n_w;
			FLASH_OE_N_O <= oe_n_w;
			FLASH_ADDR_O <= fa_w;
			FLASH_DQ_O <= fd_w;
			FLASH_DQ_OE_O <= fdoe_w;
			FLASH_BYTE_N_O <= !BYTE_MODE_I;
		end
	end
	// Low supply lockout lives in the flash; nothing to do here.
endmodule

// ---- dv/flash_host_ctrl_chk.sv ----
// Checker for the flash host controller ports.
`timescale 1ns/1ps
module flash_host_ctrl_chk
	import flash_host_pkg::*;
(
	input wire logic               CLK_SYS_I,
	input wire logic               RSTN_I,
	input wire logic               START_I,
	input wire flash_host_pkg::op_e OP_I,
	input wire logic               BYTE_MODE_I,
	input wire logic               BUSY_O,
	input wire logic               DONE_O,
	input wire logic               ERROR_O,
	input wire logic               FLASH_CE_N_O,
	input wire logic               FLASH_WE_N_O,
	input wire logic               FLASH_OE_N_O,
	input wire logic               FLASH_RESET_N_O,
	input wire logic               FLASH_BYTE_N_O,
	input wire logic               FLASH_DQ_OE_O
);
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RSTN_I);
	// Writes drive data and keep the flash outputs off.
	property p_wr; !FLASH_WE_N_O |-> FLASH_OE_N_O && FLASH_DQ_OE_O; endproperty
	a_wr: assert property (p_wr) else $error("write strobe bad");
	property p_oe; !FLASH_OE_N_O |-> !FLASH_DQ_OE_O; endproperty
	a_oe: assert property (p_oe) else $error("bus contention");
	property p_prog;
		START_I && !BUSY_O && OP_I == OP_PROG |-> ##[2:40] !FLASH_WE_N_O;
	endproperty
	a_prog: assert property (p_prog) else $error("no write");
	property p_idle; !BUSY_O |-> FLASH_CE_N_O; endproperty
	a_idle: assert property (p_idle) else $error("chip on idle");
	property p_byte; FLASH_BYTE_N_O == !$past(BYTE_MODE_I); endproperty
	a_byte: assert property (p_byte) else $error("byte pin");
	// The reset pulse must stay low for at least 8 cycles, 400 ns.
	property p_hrst; $fell(FLASH_RESET_N_O) |-> !FLASH_RESET_N_O[*8];
	endproperty
	a_hrst: assert property (p_hrst) else $error("reset short");
	property p_start; START_I && !BUSY_O |=> BUSY_O; endproperty
	a_start: assert property (p_start) else $error("not taken");
	property p_done; DONE_O |=> !DONE_O; endproperty
	a_done: assert property (p_done) else $error("done long");
	c_done: cover property (DONE_O);
	c_err: cover property ($rose(ERROR_O));
	c_rst: cover property ($fell(FLASH_RESET_N_O));
endmodule
bind flash_host_ctrl flash_host_ctrl_chk u_chk(.*);

// ---- dv/flash_dev_model.sv ----
// Behavioural model of the parallel flash device.
`timescale 1ns/1ps
module flash_dev_model
	import flash_host_pkg::*;
(
	input  wire logic        ce_n_i,
	input  wire logic        we_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        rst_n_i,
	input  wire logic        byte_n_i,
	input  wire logic [19:0] a_i,
	input  wire logic [15:0] d_i,
	output logic [15:0]      q_o,
	output logic             rb_n_o
);
	logic [15:0] mem [logic [19:0]];
	logic [15:0] pd;
	logic        byp = 0;
	logic        tog = 0;
	int          step = 0;
	int          busy = 0;
	int          wr_cnt = 0;
	logic        wr_on;
	assign rb_n_o = (busy == 0);
	// A write lands when the first of chip and write enable rises, since
	// the host releases both on one edge. Sector 31 is protected from programs only.
	assign wr_on = !we_n_i && !ce_n_i;
	always @(negedge wr_on) begin
		if (rst_n_i && busy == 0) begin
			wr_cnt++;
			case (step)
			0: step = (d_i == UNLOCK_D1) ? 1 : (byp && d_i == CMD_PROG) ? 3 :
				(byp && d_i == CMD_EXIT) ? 7 : 0;
			1: step = (d_i == UNLOCK_D2) ? 2 : 0;
			2: begin
				step = (d_i == CMD_PROG) ? 3 : (d_i == CMD_ERASE) ? 4 : 0;
				if (d_i == CMD_BYPASS) byp = 1;
			end
			3: begin
				step = 0;
				pd = d_i;
				if (a_i[19:15] != 5'h1F) begin
					mem[a_i] = d_i;
					busy = 3;
				end
			end
			4: step = (d_i == UNLOCK_D1) ? 5 : 0;
			5: step = (d_i == UNLOCK_D2) ? 6 : 0;
			6: begin
				step = 0;
				pd = 16'hFFFF;
				// Only the addressed sector is cleared.
				foreach (mem[k]) if (k[19:15] == a_i[19:15]) mem.delete(k);
				busy = 3;
			end
			7: begin
				step = 0;
				if (d_i == 16'h0000) byp = 0;
			end
			endcase
		end
	end
	// Reads give status while busy, then array data.
	// The short wait lets enable and address, changed in the same step, settle.
	always @(negedge oe_n_i) begin
		#1;
		if (!ce_n_i && busy > 0) begin
			q_o = {pd[15:8], ~pd[7], tog, pd[5:0]};
			tog = ~tog;
			busy--;
		end else if (!ce_n_i)
			q_o = mem.exists(a_i) ? mem[a_i] : 16'hFFFF;
		if (!byte_n_i) q_o[15:8] = ~q_o[15:8];
	end
	// A released bus shows the last data inverted.
	always @(posedge oe_n_i) q_o = ~q_o;
	always @(negedge rst_n_i) begin
		busy = 0;
		step = 0;
		byp = 0;
	end
	initial q_o = 16'h0000;
endmodule

// ---- dv/boot_sector_flash_command_control_tb_top.sv ----
// Testbench for the flash host controller with a flash model.
`timescale 1ns/1ps
module boot_sector_flash_command_control_tb_top;
	import flash_host_pkg::*;
	logic CLK_SYS_I = 0, RSTN_I = 0, START_I = 0, BYTE_MODE_I = 0;
	op_e  OP_I = OP_READ;
	logic [19:0] ADDR_I = 0, FLASH_ADDR_O;
	logic [15:0] DATA_I = 0, RDATA_O, FLASH_DQ_O, FLASH_DQ_I;
	logic BUSY_O, DONE_O, ERROR_O, SUSPENDED_O, FLASH_CE_N_O, FLASH_WE_N_O;
	logic FLASH_OE_N_O, FLASH_RESET_N_O, FLASH_BYTE_N_O, FLASH_DQ_OE_O;
	logic FLASH_READY_BUSY_N_I;
	int   bad_count = 0;
	int   n_checks = 0;
	int   w0;
	flash_host_ctrl DUT(.*);
	flash_dev_model u_dev(.ce_n_i(FLASH_CE_N_O), .we_n_i(FLASH_WE_N_O),
		.oe_n_i(FLASH_OE_N_O), .rst_n_i(FLASH_RESET_N_O),
		.byte_n_i(FLASH_BYTE_N_O), .a_i(FLASH_ADDR_O), .d_i(FLASH_DQ_O),
		.q_o(FLASH_DQ_I), .rb_n_o(FLASH_READY_BUSY_N_I));
	always #25 CLK_SYS_I = ~CLK_SYS_I;
	task automatic chk(logic [15:0] g, logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// One request, then a bounded wait for completion.
	task automatic op(op_e o, logic [19:0] a, logic [15:0] d);
		int n;
		@(posedge CLK_SYS_I);
		START_I <= 1;
		OP_I <= o;
		ADDR_I <= a;
		DATA_I <= d;
		@(posedge CLK_SYS_I);
		START_I <= 0;
		n = 0;
		while (DONE_O !== 1'b1 && n < 400) begin
			@(posedge CLK_SYS_I);
			n++;
		end
		chk(16'(n < 400), 16'h0001);
	endtask
	task automatic rd(logic [19:0] a, logic [15:0] e);
		op(OP_READ, a, 16'h0000);
		chk(RDATA_O, e);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog sized well beyond the expected run.
	initial begin
		#(50 * 20000);
		bad_count++;
		print_verdict;
	end
	initial begin
		repeat (3) @(posedge CLK_SYS_I);
		RSTN_I <= 1;
		rd(20'h0_1000, 16'hFFFF);
		op(OP_PROG, 20'h0_1000, 16'h1234);
		chk(16'(ERROR_O), 16'h0000);
		rd(20'h0_1000, 16'h1234);
		$display("test program done");
		op(OP_PROG, 20'hF_8000, 16'h5A5A);
		chk(16'(ERROR_O), 16'h0001);
		$display("test protected done");
		op(OP_BYPASS_ON, 20'h0_0000, 16'h0000);
		w0 = u_dev.wr_cnt;
		op(OP_BYPASS_PROG, 20'h0_2000, 16'hBEEF);
		chk(16'(u_dev.wr_cnt - w0), 16'h0002);
		op(OP_BYPASS_OFF, 20'h0_0000, 16'h0000);
		rd(20'h0_2000, 16'hBEEF);
		$display("test bypass done");
		op(OP_PROG, 20'h0_9000, 16'hABCD);
		op(OP_ERASE, 20'h0_8000, 16'h0000);
		rd(20'h0_9000, 16'hFFFF);
		rd(20'h0_1000, 16'h1234);
		$display("test erase done");
		op(OP_SUSPEND, 20'h0_9000, 16'h0000);
		chk(16'(SUSPENDED_O), 16'h0001);
		op(OP_RESUME, 20'h0_9000, 16'h0000);
		chk(16'(SUSPENDED_O), 16'h0000);
		chk(16'(ERROR_O), 16'h0000);
		$display("test suspend done");
		w0 = u_dev.wr_cnt;
		op(OP_REGION_ON, 20'h0_0000, 16'h0000);
		op(OP_REGION_OFF, 20'h0_0000, 16'h0000);
		chk(16'(u_dev.wr_cnt - w0), 16'h0007);
		$display("test region done");
		BYTE_MODE_I <= 1;
		op(OP_READ, 20'h0_1000, 16'h0000);
		chk(RDATA_O, 16'h0034);
		chk(16'(FLASH_BYTE_N_O), 16'h0000);
		BYTE_MODE_I <= 0;
		$display("test byte mode done");
		op(OP_HWRESET, 20'h0_0000, 16'h0000);
		chk(16'(FLASH_RESET_N_O), 16'h0001);
		rd(20'h0_2000, 16'hBEEF);
		$display("test hardware reset done");
		print_verdict;
	end
endmodule
